/* File: rtl/adc_conv_cfg.svh */
// Constants of the converter conversion control and parallel host port
`ifndef ADC_CONV_CFG_SVH
`define ADC_CONV_CFG_SVH

`define CONV_EDGES      4'hD
`define EDGE_CNT_RESET  4'h0
`define WORD_W          12
`define CHAN_W          3
`define LOW_BYTE_MSB    7
`define HIGH_NIB_MSB    11
`define HIGH_NIB_LSB    8
`define BUF_DEPTH       2'h2
`define BUF_CNT_RESET   2'h0
`define STROBE_IDLE     1'b1

`endif

/* File: rtl/adc_conv_pkg.sv */
// Types shared by the converter conversion control block
`include "adc_conv_cfg.svh"

package adc_conv_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_COUNT,
        ST_DONE
    } conv_state_e;

    // Pin levels as seen on one clock edge
    typedef struct packed {
        logic       trig_n;
        logic       mclk;
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       wb;
        logic       b8;
        logic [7:0] low;
        logic [2:0] high;
    } pins_s;

    typedef struct packed {
        logic [`WORD_W-1:0] result;
        logic [`CHAN_W-1:0] chan;
    } result_s;

endpackage

/* File: rtl/adc_parallel_conversion_ctrl.sv */
// Conversion control and three-state parallel host port of the converter
`timescale 1ns/10ps
`default_nettype none
`include "adc_conv_cfg.svh"

module adc_parallel_conversion_ctrl (
    input  wire logic                       clk_in,                 // 200 MHz
    input  wire logic                       reset_n_in,             // Async
    input  wire logic                       sample_trigger_n_in,    // Pin
    input  wire logic                       master_clock_input_in,  // Pin
    input  wire logic                       cs_n_in,                // Pin
    input  wire logic                       rd_n_in,                // Pin
    input  wire logic                       wr_n_in,                // Pin
    input  wire logic                       word_byte_sel_in,       // 1=word
    input  wire logic [7:0]                 bus_lines_low_in,       // Pin in
    output logic      [7:0]                 bus_lines_low_out,      // Pin out
    output logic      [7:0]                 bus_lines_low_oe_out,   // Drive
    input  wire logic                       bit8_or_upper_select_in,
    output logic                            bit8_or_upper_select_out,
    output logic                            bit8_or_upper_select_oe_out,
    input  wire logic [2:0]                 bus_lines_high_in,      // Pin in
    output logic      [2:0]                 bus_lines_high_out,     // Pin out
    output logic      [2:0]                 bus_lines_high_oe_out,  // Drive
    output logic                            busy_out,               // Busy
    output logic                            hold_out,               // 1=hold
    input  wire logic [`WORD_W-1:0]         conv_data_in,           // SAR word
    input  wire logic [`CHAN_W-1:0]         channel_in,             // Chan id
    input  wire logic                       auto_powerdown_in,      // Asleep
    output logic                            wake_out,               // Pulse
    output logic                            wr_valid_out,           // Word ok
    output logic      [`WORD_W-1:0]         wr_data_out,            // Word
    input  wire logic                       wr_ready_in,            // Taken
    output logic                            wr_space_out            // Room
);
    import adc_conv_pkg::*;

    // Synchronisers come out of reset at the pins' idle levels, so the
    // release shows no false strobe, bus drive or trigger edge
    localparam pins_s PINS_IDLE = '{trig_n: `STROBE_IDLE, mclk: 1'b0,
                                   cs_n: `STROBE_IDLE, rd_n: `STROBE_IDLE,
                                   wr_n: `STROBE_IDLE, wb: 1'b0, b8: 1'b0,
                                   low: 8'h00, high: 3'h0};

    typedef struct packed {
        pins_s                        s1;
        pins_s                        s2;
        pins_s                        cap;
        logic                         trig_d;
        logic                         mclk_d;
        logic                         wr_act_d;
        conv_state_e                  st;
        logic [3:0]                   edges;
        logic                         busy;
        logic                         hold;
        result_s                      res;
        logic [7:0]                   lo_byte;
        logic                         wake;
        logic [7:0]                   d_low;
        logic                         d_b8;
        logic [2:0]                   d_high;
        logic                         oe_low;
        logic                         oe_b8;
        logic [1:0]                   cnt;
        logic [1:0][`WORD_W-1:0]      buffer;
    } state_s;

    state_s                 st_r;
    state_s                 st_nxt;
    logic [1:0]             rst_pipe_r;
    logic                   rst_n;
    logic                   commit;
    logic                   push;
    logic                   pop;
    logic [`WORD_W-1:0]     push_word;
    logic                   trig_fall;

    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // Places the word being read on the pins for the current bus mode
    function automatic logic [`WORD_W-1:0] read_lines(
        input logic wb, input logic upper, input result_s r);
        logic [`WORD_W-1:0] w;
        w = r.result;
        if (!wb && upper) begin
            w = {4'h0, 1'b0, r.chan,
                 r.result[`HIGH_NIB_MSB:`HIGH_NIB_LSB]};
        end else if (!wb) begin
            w = {4'h0, r.result[`LOW_BYTE_MSB:0]};
        end
        return w;
    endfunction

    always_comb begin
        logic [`WORD_W-1:0] rd_word;
        logic               rd_act;
        logic               wr_act;
        logic               mclk_rise;
        logic               mclk_fall;
        logic               trig_rise;
        rd_word = '0;
        rd_act = 1'b0;
        wr_act = 1'b0;
        mclk_rise = 1'b0;
        mclk_fall = 1'b0;
        trig_rise = 1'b0;
        st_nxt = st_r;
        // Every pin passes two flops before any logic looks at it
        st_nxt.s1 = '{trig_n: sample_trigger_n_in,
                      mclk:   master_clock_input_in,
                      cs_n:   cs_n_in,
                      rd_n:   rd_n_in,
                      wr_n:   wr_n_in,
                      wb:     word_byte_sel_in,
                      b8:     bit8_or_upper_select_in,
                      low:    bus_lines_low_in,
                      high:   bus_lines_high_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.trig_d = st_r.s2.trig_n;
        st_nxt.mclk_d = st_r.s2.mclk;
        trig_fall = st_r.trig_d && !st_r.s2.trig_n;
        trig_rise = !st_r.trig_d && st_r.s2.trig_n;
        mclk_rise = !st_r.mclk_d && st_r.s2.mclk;
        mclk_fall = st_r.mclk_d && !st_r.s2.mclk;

        st_nxt.wake = trig_rise && auto_powerdown_in;

        // Only edges are counted, so gaps in a burst clock do no harm
        case (st_r.st)
            ST_IDLE: begin
                if (trig_fall) begin
                    st_nxt.st = ST_SETUP;
                    st_nxt.hold = 1'b1;
                    st_nxt.busy = 1'b1;
                    st_nxt.edges = `EDGE_CNT_RESET;
                end
            end
            ST_SETUP: begin
                if (mclk_fall) begin
                    st_nxt.st = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (mclk_rise) begin
                    st_nxt.edges = st_r.edges + 4'h1;
                    if (st_r.edges + 4'h1 == `CONV_EDGES) begin
                        st_nxt.hold = 1'b0;
                        st_nxt.res = '{result: conv_data_in,
                                       chan:   channel_in};
                        st_nxt.st = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                // Busy falls a cycle after the result register loads
                st_nxt.busy = 1'b0;
                st_nxt.st = ST_IDLE;
            end
            default: begin
                st_nxt.st = ST_IDLE;
                st_nxt.busy = 1'b0;
                st_nxt.hold = 1'b0;
            end
        endcase

        // Read side: drive only while select and read strobe are low
        rd_act = !st_r.s2.cs_n && !st_r.s2.rd_n;
        rd_word = read_lines(st_r.s2.wb, st_r.s2.b8, st_r.res);
        st_nxt.oe_low = rd_act;
        st_nxt.oe_b8 = rd_act && st_r.s2.wb;
        st_nxt.d_low = rd_word[7:0];
        st_nxt.d_b8 = rd_word[8];
        st_nxt.d_high = rd_word[11:9];

        // Write side: bus sampled while strobe is low, taken at its end
        wr_act = !st_r.s2.cs_n && !st_r.s2.wr_n;
        st_nxt.wr_act_d = wr_act;
        if (wr_act) begin
            st_nxt.cap = st_r.s2;
        end
        commit = st_r.wr_act_d && !wr_act;
        push_word = {st_r.cap.high, st_r.cap.b8, st_r.cap.low};
        push = 1'b0;
        if (commit && st_r.cap.wb) begin
            push = 1'b1;
        end else if (commit && !st_r.cap.b8) begin
            st_nxt.lo_byte = st_r.cap.low;
        end else if (commit) begin
            // Lines 4 to 7 of an upper byte carry zeros and are dropped
            push_word = {st_r.cap.low[3:0], st_r.lo_byte};
            push = 1'b1;
        end

        // Two-entry buffer; a write that finds it full is refused unless a word is popped in the same cycle
        pop = wr_ready_in && (st_r.cnt != `BUF_CNT_RESET);
        push = push && (st_r.cnt != `BUF_DEPTH || pop);
        if (pop) begin
            st_nxt.buffer[0] = st_r.buffer[1];
        end
        if (push) begin
            st_nxt.buffer[st_r.cnt - {1'b0, pop}] = push_word;
        end
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.s1 <= PINS_IDLE;
            st_r.s2 <= PINS_IDLE;
            st_r.trig_d <= `STROBE_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_lines_low_out = st_r.d_low;
    assign bus_lines_low_oe_out = {8{st_r.oe_low}};
    assign bit8_or_upper_select_out = st_r.d_b8;
    assign bit8_or_upper_select_oe_out = st_r.oe_b8;
    assign bus_lines_high_out = st_r.d_high;
    assign bus_lines_high_oe_out = {3{st_r.oe_b8}};
    assign busy_out = st_r.busy;
    assign hold_out = st_r.hold;
    assign wake_out = st_r.wake;
    assign wr_valid_out = st_r.cnt != `BUF_CNT_RESET;
    assign wr_data_out = st_r.buffer[0];
    assign wr_space_out = st_r.cnt != `BUF_DEPTH;

    a_busy_rise: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        trig_fall && st_r.st == ST_IDLE |=> busy_out && hold_out)
        else $error("busy or hold did not rise after trigger fall");

    a_busy_stays: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        busy_out && st_r.st != ST_DONE |=> busy_out)
        else $error("busy dropped during conversion");

    a_result_first: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        $fell(busy_out) |-> !hold_out && $past(!hold_out)
            && st_r.res.result == $past(conv_data_in, 2))
        else $error("busy fell before result was loaded");

    a_track_edge: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        $fell(hold_out) |-> st_r.edges == `CONV_EDGES)
        else $error("track resumed at wrong master clock edge");

    a_idle_low: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        st_r.st == ST_IDLE && !trig_fall |=> !busy_out)
        else $error("busy rose without trigger fall");

    a_read_drive: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        (st_r.s2.cs_n || st_r.s2.rd_n) |=> bus_lines_low_oe_out == 8'h00
            && !bit8_or_upper_select_oe_out)
        else $error("data lines driven while not read");

    a_bit8_mode: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        !st_r.s2.wb && !st_r.s2.cs_n && !st_r.s2.rd_n
            |=> bus_lines_low_oe_out == 8'hFF && !bit8_or_upper_select_oe_out)
        else $error("byte mode read drove the shared pin");

    a_upper_read: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        !st_r.s2.wb && st_r.s2.b8 |=> bus_lines_low_out ==
            {1'b0, $past(st_r.res.chan), $past(st_r.res.result[11:8])})
        else $error("upper byte read content wrong");

    a_write_word: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        commit && st_r.cap.wb && st_r.cnt == `BUF_CNT_RESET
            |=> wr_valid_out && wr_data_out == $past(push_word))
        else $error("word write not captured");

    a_wake_pulse: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        !st_r.trig_d && st_r.s2.trig_n && auto_powerdown_in |=> wake_out)
        else $error("no wake after trigger rise");

endmodule // adc_parallel_conversion_ctrl
`default_nettype wire

/* File: test/host_bus_model.sv */
// Host side of the three-state parallel bus, resolving every shared line
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    input  wire logic        clk_in,      // Bench clock
    input  wire logic [11:0] host_en_in,  // Host drives line
    input  wire logic [11:0] host_val_in, // Host level
    input  wire logic [11:0] dev_en_in,   // Device drives line
    input  wire logic [11:0] dev_val_in,  // Device level
    output logic      [11:0] bus_out,     // Resolved lines
    output logic             clash_out    // Sticky: both sides drove
);
    logic [11:0] last_r = 12'h000;
    // A released line keeps toggling so a stale level never reads as valid
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            bus_out[i] = host_en_in[i] ? host_val_in[i] :
                         dev_en_in[i] ? dev_val_in[i] : ~last_r[i];
        end
    end
    initial clash_out = 1'h0;
    always @(posedge clk_in) begin
        last_r <= bus_out;
        if (|(host_en_in & dev_en_in)) clash_out <= 1'h1;
    end
endmodule // host_bus_model
`default_nettype wire

/* File: test/tb_adc_parallel_conversion_ctrl.sv */
// Self-checking bench for the conversion control and parallel host port
`timescale 1ns/10ps
`default_nettype none
module tb_adc_parallel_conversion_ctrl;
    logic        clk_in, reset_n, trig_n, mclk, cs_n, rd_n, wr_n, wb;
    logic        apd, wr_ready, b8_out, b8_oe, busy, hold, wake;
    logic        wr_valid, wr_space, clash, hold_q, busy_at_track;
    logic [11:0] h_en, h_val, bus, conv_d, wr_data;
    logic [7:0]  lo_out, lo_oe;
    logic [2:0]  hi_out, hi_oe, chan;
    int          num_errors, samples_checked, k;
    logic [11:0] dtab [2] = '{12'hA5C, 12'h3F1};
    logic [2:0]  ctab [2] = '{3'h5, 3'h2};

    initial begin
        clk_in = 1'h0;
        forever #2.5 clk_in = ~clk_in;
    end

    adc_parallel_conversion_ctrl dut (
        .clk_in(clk_in), .reset_n_in(reset_n), .sample_trigger_n_in(trig_n),
        .master_clock_input_in(mclk), .cs_n_in(cs_n), .rd_n_in(rd_n),
        .wr_n_in(wr_n), .word_byte_sel_in(wb), .bus_lines_low_in(bus[7:0]),
        .bus_lines_low_out(lo_out), .bus_lines_low_oe_out(lo_oe),
        .bit8_or_upper_select_in(bus[8]), .bit8_or_upper_select_out(b8_out),
        .bit8_or_upper_select_oe_out(b8_oe), .bus_lines_high_in(bus[11:9]),
        .bus_lines_high_out(hi_out), .bus_lines_high_oe_out(hi_oe),
        .busy_out(busy), .hold_out(hold), .conv_data_in(conv_d),
        .channel_in(chan), .auto_powerdown_in(apd), .wake_out(wake),
        .wr_valid_out(wr_valid), .wr_data_out(wr_data),
        .wr_ready_in(wr_ready), .wr_space_out(wr_space));

    host_bus_model host (
        .clk_in(clk_in), .host_en_in(h_en), .host_val_in(h_val),
        .dev_en_in({hi_oe, b8_oe, lo_oe}), .dev_val_in({hi_out, b8_out, lo_out}),
        .bus_out(bus), .clash_out(clash));

    // Remembers whether busy was still up on the cycle the sampler let go
    always @(negedge clk_in) begin
        hold_q <= hold;
        if (hold_q === 1'h1 && hold === 1'h0) busy_at_track <= busy;
    end

    task automatic chk(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 60) begin
            chk("wait bound", 12'h000, 12'h001);
            tally_and_finish();
        end
    endtask

    task automatic rd(input logic w, input logic up, input logic [11:0] exp,
                      input string what);
        int n;
        wb = w;
        h_en = {3'h0, ~w, 8'h00};
        h_val = {3'h0, up, 8'h00};
        cs_n = 1'h0;
        rd_n = 1'h0;
        for (n = 0; n < 60 && lo_oe[0] !== 1'h1; n++) @(negedge clk_in);
        tmo(n);
        @(negedge clk_in);
        chk(what, w ? bus : {4'h0, bus[7:0]}, exp);
        if (w) chk("upper lines driven", {9'h0, hi_oe}, 12'h007);
        cs_n = 1'h1;
        rd_n = 1'h1;
        for (n = 0; n < 60 && lo_oe[0] !== 1'h0; n++) @(negedge clk_in);
        tmo(n);
        chk("bus released", {hi_oe, b8_oe, lo_oe}, 12'h000);
    endtask

    // Byte writes keep the select pin driven; word writes drive all lines
    task automatic wr(input logic w, input logic up, input logic [11:0] d);
        wb = w;
        h_val = w ? d : {3'h0, up, d[7:0]};
        h_en = w ? 12'hFFF : 12'h1FF;
        cs_n = 1'h0;
        wr_n = 1'h0;
        repeat (4) @(negedge clk_in);
        cs_n = 1'h1;
        wr_n = 1'h1;
        repeat (4) @(negedge clk_in);
        h_en = {3'h0, ~w, 8'h00};
        repeat (2) @(negedge clk_in);
    endtask

    task automatic pop(input logic [11:0] exp);
        chk("word waiting", {11'h0, wr_valid}, 12'h001);
        chk("queued word", wr_data, exp);
        wr_ready = 1'h1;
        @(negedge clk_in);
        wr_ready = 1'h0;
        @(negedge clk_in);
    endtask

    task automatic conv(input logic [11:0] d, input logic [2:0] ch);
        int n, rises;
        logic fell;
        conv_d = d;
        chan = ch;
        apd = 1'h1;
        trig_n = 1'h0;
        for (n = 0; n < 60 && busy !== 1'h1; n++) @(negedge clk_in);
        tmo(n);
        chk("hold at start", {11'h0, hold}, 12'h001);
        trig_n = 1'h1;
        for (n = 0; n < 60 && wake !== 1'h1; n++) @(negedge clk_in);
        tmo(n);
        chk("busy during wake", {11'h0, busy}, 12'h001);
        rises = 0;
        fell = 1'h0;
        busy_at_track = 1'h0;
        // Burst of master clock only around the conversion; rises count
        // only once the first falling edge has closed the setup interval
        repeat (16) begin
            if (mclk === 1'h1) fell = 1'h1;
            mclk = 1'h0;
            repeat (4) @(negedge clk_in);
            mclk = 1'h1;
            if (hold === 1'h1 && fell) rises++;
            repeat (4) @(negedge clk_in);
        end
        chk("rises in hold", 12'(rises), 12'h00D);
        chk("busy at track", {11'h0, busy_at_track}, 12'h001);
        chk("busy after", {11'h0, busy}, 12'h000);
        repeat (20) @(negedge clk_in);
        chk("busy idle", {11'h0, busy}, 12'h000);
        apd = 1'h0;
    endtask

    initial begin
        {reset_n, mclk, wb, apd, wr_ready} = 5'h00;
        {trig_n, cs_n, rd_n, wr_n} = 4'hF;
        {h_en, h_val, conv_d, chan} = 39'h0;
        {num_errors, samples_checked, busy_at_track} = 0;
        repeat (6) @(negedge clk_in);
        reset_n = 1'h1;
        repeat (6) @(negedge clk_in);
        chk("reset", {busy, hold, wake, wr_valid, lo_oe}, 12'h000);
        for (k = 0; k < 2; k++) begin
            conv(dtab[k], ctab[k]);
            rd(1'h1, 1'h0, dtab[k], "word read");
            rd(1'h0, 1'h0, {4'h0, dtab[k][7:0]}, "low byte");
            rd(1'h0, 1'h1, {5'h0, ctab[k], dtab[k][11:8]}, "high");
            $display("test conversion %0d done", k);
        end
        wr(1'h1, 1'h0, 12'hC3A);
        wr(1'h0, 1'h0, 12'h05B);
        wr(1'h0, 1'h1, 12'h009);
        wr(1'h1, 1'h0, 12'h777);
        chk("space when full", {11'h0, wr_space}, 12'h000);
        pop(12'hC3A);
        pop(12'h95B);
        chk("drained", {11'h0, wr_valid}, 12'h000);
        $display("test writes done");
        chk("bus clash", {11'h0, clash}, 12'h000);
        tally_and_finish();
    end
endmodule // tb_adc_parallel_conversion_ctrl
`default_nettype wire
